// ---- scp_device.sv ----
// Function
// - Sample on rising edge, read valid falling
// - Bidirectional default; config bit 7 selects output
// - Chip select high releases both data lines
// - Host starts with select low, 16-bit instruction
// - Select may stall at byte boundaries except during stream data, where a rise ends the transfer
// - Short low burst then high aborts transfer
// - Non-byte-boundary select rise resets port
// - Streaming moves any number of bytes up to address 0x232
// - Instruction: read flag, length, 13-bit address
// - Length codes: one, two, three, stream
// - Host sends top address bits as zero
// - Writes buffered; update bit commits all
// - Read shifts N bytes or until select rises
// - Readback source chosen by control bit
// - Host mirrors configuration nibbles; default 0x18
// - Bit order change takes effect immediately
// - MSB first: address decrements toward zero
// - LSB first: address increments toward 0x232
// - Streaming stops at address 0x232
// - No address skipped during multibyte transfers
// - Soft reset bits restore defaults, held
module scp_device (
   // Clock and reset
   input wire logic clk,
   input wire logic srst,
   // Serial link, device side
   scp_if.dev link,
   // Active register tap for the rest of the chip
   input wire logic [9:0] tap_addr,
   output logic [7:0] tap_data,
   output logic update_pulse
);
   typedef enum logic [1:0] {
      ST_INSTR = 2'h0,
      ST_DATA = 2'h1,
      ST_DONE = 2'h2
   } scp_dst_t;

   logic [2:0] pins_s;
   logic sclk_prev_q;
   logic cs_prev_q;
   scp_dst_t state_q;
   scp_dst_t state_d;
   logic [3:0] bit_q;
   logic [3:0] bit_d;
   logic [15:0] sh_q;
   logic rw_q;
   logic rw_d;
   scp_pkg::scp_len_t len_q;
   scp_pkg::scp_len_t len_d;
   logic [9:0] addr_q;
   logic [9:0] addr_d;
   logic [1:0] cnt_q;
   logic [1:0] cnt_d;
   logic [7:0] rsh_q;
   logic [7:0] rsh_d;
   logic dout_q;
   logic sdio_oe_n_q;
   logic sdo_oe_n_q;
   logic [7:0] tap_q;
   logic upd_q;
   logic [7:0] buf_q [0:scp_pkg::REG_COUNT-1];
   logic [7:0] act_q [0:scp_pkg::REG_COUNT-1];

   // ***********************************************
   // Link sampling
   // ***********************************************
   scp_sync #(
      .W(3),
      .RST_VAL(3'h4)
   ) u_sync (
      .clk(clk),
      .srst(srst),
      .d({link.cs_n, link.sclk, link.sdio}),
      .q(pins_s)
   );

   wire cs_n_s = pins_s[2];
   wire sclk_s = pins_s[1];
   wire sdio_s = pins_s[0];
   wire sclk_rise = sclk_s & ~sclk_prev_q;
   wire cs_rise = cs_n_s & ~cs_prev_q;

   // ***********************************************
   // Decoding
   // ***********************************************
   wire [7:0] cfg = act_q[scp_pkg::ADDR_PORT_CFG];
   wire lsb_first = cfg[scp_pkg::CFG_LSB_BIT];
   wire sdo_mode = cfg[scp_pkg::CFG_SDO_BIT];
   wire soft_rst = cfg[scp_pkg::CFG_SRST_HI] & cfg[scp_pkg::CFG_SRST_LO];
   wire rb_active = act_q[scp_pkg::ADDR_RB_SEL][scp_pkg::RB_ACTIVE_BIT];

   wire take = sclk_rise & ~cs_n_s & (state_q != ST_DONE);
   wire [15:0] sh_nx = lsb_first ? {sdio_s, sh_q[15:1]} : {sh_q[14:0], sdio_s};
   wire [3:0] unit_last = (state_q == ST_INSTR) ? scp_pkg::INSTR_LAST : scp_pkg::BYTE_LAST;
   wire unit_end = take & (bit_q == unit_last);
   wire [7:0] rx_byte = lsb_first ? sh_nx[15:8] : sh_nx[7:0];

   wire at_bottom = addr_q == scp_pkg::ADDR_PORT_CFG;
   wire [9:0] dec_addr = at_bottom ? scp_pkg::ADDR_UPDATE : addr_q - scp_pkg::ADDR_STEP;
   wire [9:0] next_addr = lsb_first ? addr_q + scp_pkg::ADDR_STEP : dec_addr;
   wire stream_end = addr_q == scp_pkg::ADDR_UPDATE;
   wire last_byte = (len_q == scp_pkg::LEN_STREAM) ? stream_end : (cnt_q == len_q);

   wire byte_end = unit_end & (state_q == ST_DATA);
   wire wr_byte = byte_end & ~rw_q & (addr_q < scp_pkg::REG_COUNT);
   wire do_update = wr_byte & stream_end & rx_byte[scp_pkg::UPDATE_BIT];
   wire immediate = at_bottom | (addr_q == scp_pkg::ADDR_RB_SEL);

   wire [9:0] fetch_addr = (state_q == ST_INSTR) ? sh_nx[scp_pkg::ADDR_MSB:0] : next_addr;
   wire fetch_ok = fetch_addr < scp_pkg::REG_COUNT;
   wire [7:0] fetch_src = rb_active ? act_q[fetch_addr] : buf_q[fetch_addr];
   wire [7:0] fetch_byte = fetch_ok ? fetch_src : 8'h00;

   // Stalls are legal only on byte edges; any other rise drops the transfer.
   wire misaligned = bit_q[2:0] != 3'h0;
   wire stream_stop = (state_q == ST_DATA) & (len_q == scp_pkg::LEN_STREAM);
   wire abort = cs_rise & (misaligned | stream_stop | (state_q == ST_DONE));

   // ***********************************************
   // Transfer state machine
   // ***********************************************
   always_comb begin
      state_d = state_q;
      bit_d = bit_q;
      rw_d = rw_q;
      len_d = len_q;
      addr_d = addr_q;
      cnt_d = cnt_q;
      rsh_d = rsh_q;
      if (abort) begin
         state_d = ST_INSTR;
         bit_d = 4'h0;
         cnt_d = 2'h0;
      end else if (take) begin
         bit_d = bit_q + 4'h1;
         rsh_d = lsb_first ? (rsh_q >> 1) : (rsh_q << 1);
         if (unit_end) begin
            bit_d = 4'h0;
            case (state_q)
               ST_INSTR: begin
                  rw_d = sh_nx[scp_pkg::RW_BIT];
                  len_d = scp_pkg::scp_len_t'(sh_nx[scp_pkg::LEN_HI:scp_pkg::LEN_LO]);
                  addr_d = sh_nx[scp_pkg::ADDR_MSB:0];
                  cnt_d = 2'h0;
                  rsh_d = fetch_byte;
                  state_d = ST_DATA;
               end
               ST_DATA: begin
                  if (last_byte) begin
                     state_d = ST_DONE;
                  end else begin
                     addr_d = next_addr;
                     cnt_d = cnt_q + 2'h1;
                     rsh_d = fetch_byte;
                  end
               end
               default: begin
                  state_d = ST_INSTR;
               end
            endcase
         end
      end
   end

   wire reading = rw_d & (state_d != ST_INSTR) & ~cs_n_s;
   wire dout_d = lsb_first ? rsh_d[0] : rsh_d[7];

   always_ff @(posedge clk) begin
      if (srst) begin
         state_q <= ST_INSTR;
         bit_q <= 4'h0;
         rw_q <= 1'h0;
         len_q <= scp_pkg::LEN_ONE;
         addr_q <= 10'h000;
         cnt_q <= 2'h0;
         rsh_q <= 8'h00;
      end else begin
         state_q <= state_d;
         bit_q <= bit_d;
         rw_q <= rw_d;
         len_q <= len_d;
         addr_q <= addr_d;
         cnt_q <= cnt_d;
         rsh_q <= rsh_d;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         sh_q <= 16'h0000;
         sclk_prev_q <= 1'h0;
         cs_prev_q <= 1'h1;
         dout_q <= 1'h0;
         sdio_oe_n_q <= 1'h1;
         sdo_oe_n_q <= 1'h1;
      end else begin
         sh_q <= take ? sh_nx : sh_q;
         sclk_prev_q <= sclk_s;
         cs_prev_q <= cs_n_s;
         dout_q <= dout_d;
         sdio_oe_n_q <= ~(reading & ~sdo_mode);
         sdo_oe_n_q <= ~(reading & sdo_mode);
      end
   end

   // ***********************************************
   // Buffer and active registers
   // ***********************************************
   // Port configuration and readback select act at once, so they are
   // written through to the active copy as well as the buffer.
   always_ff @(posedge clk) begin
      if (srst) begin
         for (int i = 0; i < scp_pkg::REG_COUNT; i++) begin
            buf_q[i] <= 8'h00;
            act_q[i] <= 8'h00;
         end
         buf_q[scp_pkg::ADDR_PORT_CFG] <= scp_pkg::PORT_CFG_RST;
         act_q[scp_pkg::ADDR_PORT_CFG] <= scp_pkg::PORT_CFG_RST;
      end else begin
         if (soft_rst) begin
            for (int i = 1; i < scp_pkg::REG_COUNT; i++) begin
               buf_q[i] <= 8'h00;
               act_q[i] <= 8'h00;
            end
         end else if (do_update) begin
            for (int i = 0; i < scp_pkg::REG_COUNT; i++) begin
               act_q[i] <= buf_q[i];
            end
         end
         if (wr_byte & ~stream_end) begin
            buf_q[addr_q] <= rx_byte;
            if (immediate) begin
               act_q[addr_q] <= rx_byte;
            end
         end
      end
   end

   wire [7:0] tap_d = (tap_addr < scp_pkg::REG_COUNT) ? act_q[tap_addr] : 8'h00;

   always_ff @(posedge clk) begin
      if (srst) begin
         tap_q <= 8'h00;
         upd_q <= 1'h0;
      end else begin
         tap_q <= tap_d;
         upd_q <= do_update;
      end
   end

   assign tap_data = tap_q;
   assign update_pulse = upd_q;
   assign link.dev_sdio_drv = dout_q;
   assign link.dev_sdo_drv = dout_q;
   assign link.dev_sdio_oe_n = sdio_oe_n_q;
   assign link.dev_sdo_oe_n = sdo_oe_n_q;
endmodule : scp_device

// ---- scp_pkg.sv ----
package scp_pkg;

   // ***********************************************
   // Timing
   // ***********************************************
   localparam int CLK_PERIOD_NS = 50;
   // The controller's own serial clock; slow enough for both ends to
   // oversample every pin through a two-stage synchroniser.
   localparam int SCLK_PERIOD_NS = 800;
   localparam int SCLK_HALF_CYC = SCLK_PERIOD_NS / (2 * CLK_PERIOD_NS);
   localparam logic [7:0] HALF_LAST = 8'(SCLK_HALF_CYC - 1);

   // ***********************************************
   // Instruction word
   // ***********************************************
   localparam int RW_BIT = 15;
   localparam int LEN_HI = 14;
   localparam int LEN_LO = 13;
   localparam int ADDR_RSV_HI = 12;
   localparam int ADDR_RSV_LO = 10;
   localparam int ADDR_MSB = 9;
   localparam logic [3:0] INSTR_LAST = 4'hF;
   localparam logic [3:0] BYTE_LAST = 4'h7;
   localparam logic [5:0] INSTR_BITS = 6'h10;

   typedef enum logic [1:0] {
      LEN_ONE = 2'h0,
      LEN_TWO = 2'h1,
      LEN_THREE = 2'h2,
      LEN_STREAM = 2'h3
   } scp_len_t;

   // ***********************************************
   // Device register map
   // ***********************************************
   localparam logic [9:0] ADDR_PORT_CFG = 10'h000;
   localparam logic [9:0] ADDR_RB_SEL = 10'h004;
   localparam logic [9:0] ADDR_UPDATE = 10'h232;
   localparam logic [9:0] ADDR_STEP = 10'h001;
   localparam logic [9:0] REG_COUNT = 10'h233;
   localparam logic [7:0] PORT_CFG_RST = 8'h18;
   localparam int CFG_SDO_BIT = 7;
   localparam int CFG_LSB_BIT = 6;
   localparam int CFG_SRST_HI = 5;
   localparam int CFG_SRST_LO = 2;
   localparam int RB_ACTIVE_BIT = 0;
   localparam int UPDATE_BIT = 0;

   // ***********************************************
   // Controller register port
   // ***********************************************
   localparam logic [7:0] HREG_CMD = 8'h00;
   localparam logic [7:0] HREG_WDATA = 8'h04;
   localparam logic [7:0] HREG_RDATA = 8'h08;
   localparam logic [7:0] HREG_STATUS = 8'h0C;
   localparam logic [7:0] HREG_CFG = 8'h10;
   localparam int HCFG_LSB = 0;
   localparam int HCFG_SDO = 1;
   localparam int HCFG_SCNT = 8;

   function automatic logic [7:0] rev8(input logic [7:0] v);
      return {v[0], v[1], v[2], v[3], v[4], v[5], v[6], v[7]};
   endfunction : rev8

endpackage : scp_pkg

// ---- scp_if.sv ----
interface scp_if;
   logic cs_n;
   logic sclk;
   logic host_sdio_drv;
   logic host_sdio_oe_n;
   logic dev_sdio_drv;
   logic dev_sdio_oe_n;
   logic dev_sdo_drv;
   logic dev_sdo_oe_n;
   logic sdio;
   logic sdo;

   // Undriven lines read high, standing in for a pull-up.
   assign sdio = !host_sdio_oe_n ? host_sdio_drv : (!dev_sdio_oe_n ? dev_sdio_drv : 1'h1);
   assign sdo = !dev_sdo_oe_n ? dev_sdo_drv : 1'h1;

   modport host (
      output cs_n, sclk, host_sdio_drv, host_sdio_oe_n,
      input sdio, sdo
   );
   modport dev (
      input cs_n, sclk, sdio,
      output dev_sdio_drv, dev_sdio_oe_n, dev_sdo_drv, dev_sdo_oe_n
   );
endinterface : scp_if

// ---- scp_sync.sv ----
module scp_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] RST_VAL = '0
) (
   // Clock and reset
   input wire logic clk,
   input wire logic srst,
   // Asynchronous in, synchronised out
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_q;
   logic [W-1:0] sync_q;

   always_ff @(posedge clk) begin
      if (srst) begin
         meta_q <= RST_VAL;
         sync_q <= RST_VAL;
      end else begin
         meta_q <= d;
         sync_q <= meta_q;
      end
   end

   assign q = sync_q;
endmodule : scp_sync

// ---- scp_host.sv ----
module scp_host (
   // Clock and reset
   input wire logic clk,
   input wire logic srst,
   // Serial link, controller side
   scp_if.host link,
   // Register port
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata
);
   typedef enum logic [2:0] {
      H_IDLE = 3'h0,
      H_LEAD = 3'h1,
      H_LOW = 3'h2,
      H_HIGH = 3'h3,
      H_TAIL = 3'h4
   } scp_hst_t;

   logic [1:0] pins_s;
   scp_hst_t state_q;
   logic [7:0] half_q;
   logic [5:0] bit_q;
   logic [5:0] last_q;
   logic [47:0] tx_q;
   logic [31:0] rx_q;
   logic rd_q;
   logic [9:0] cfg_q;
   logic [31:0] wdata_q;
   logic [31:0] rdata_q;
   logic cs_n_q;
   logic sclk_q;
   logic drv_q;
   logic oe_n_q;
   logic [15:0] instr;
   logic [9:0] badr;
   logic [7:0] b;
   logic [47:0] seq;
   logic [31:0] rx_conv;

   scp_sync #(
      .W(2),
      .RST_VAL(2'h3)
   ) u_sync (
      .clk(clk),
      .srst(srst),
      .d({link.sdio, link.sdo}),
      .q(pins_s)
   );

   wire lsb = cfg_q[scp_pkg::HCFG_LSB];
   wire din = cfg_q[scp_pkg::HCFG_SDO] ? pins_s[0] : pins_s[1];
   wire busy = state_q != H_IDLE;
   wire start = reg_wr & (reg_addr == scp_pkg::HREG_CMD) & ~busy;
   wire half_done = half_q == scp_pkg::HALF_LAST;
   wire [1:0] len = reg_wdata[scp_pkg::LEN_HI:scp_pkg::LEN_LO];
   wire [1:0] nb_m1 = (len == scp_pkg::LEN_STREAM) ? cfg_q[scp_pkg::HCFG_SCNT +: 2] : len;
   wire [5:0] last_d = 6'({nb_m1, 3'h7}) + scp_pkg::INSTR_BITS;
   // The first read bit is launched after the last instruction rise, so it is
   // caught at that bit's own fall, and the final rise of the frame brings none.
   wire [5:0] rx_first = 6'(scp_pkg::INSTR_LAST);
   wire in_data = (bit_q >= rx_first) & (bit_q != last_q);
   wire [4:0] rx_idx = 5'(bit_q - rx_first);
   wire turn = rd_q & (state_q == H_HIGH) & (half_q == 8'h00) & (bit_q == rx_first);

   // ***********************************************
   // Serial image of one transfer
   // ***********************************************
   always_comb begin
      instr = reg_wdata[15:0];
      instr[scp_pkg::ADDR_RSV_HI:scp_pkg::ADDR_RSV_LO] = 3'h0;
      seq = 48'h0;
      seq[15:0] = lsb ? instr : {scp_pkg::rev8(instr[7:0]), scp_pkg::rev8(instr[15:8])};
      badr = 10'h000;
      b = 8'h00;
      for (int k = 0; k < 4; k++) begin
         badr = lsb ? instr[9:0] + 10'(k) : instr[9:0] - 10'(k);
         b = wdata_q[8*k +: 8];
         if (~instr[scp_pkg::RW_BIT] & (badr == scp_pkg::ADDR_PORT_CFG)) begin
            b = {b[7:4], b[4], b[5], b[6], b[7]};
         end
         seq[16 + 8*k +: 8] = lsb ? b : scp_pkg::rev8(b);
      end
   end

   // ***********************************************
   // Serial sequencer
   // ***********************************************
   always_ff @(posedge clk) begin
      if (srst) begin
         state_q <= H_IDLE;
         half_q <= 8'h00;
         cs_n_q <= 1'h1;
         sclk_q <= 1'h0;
      end else begin
         half_q <= (~busy | half_done) ? 8'h00 : half_q + 8'h01;
         case (state_q)
            H_IDLE: begin
               if (start) begin
                  cs_n_q <= 1'h0;
                  state_q <= H_LEAD;
               end
            end
            H_LEAD: state_q <= half_done ? H_LOW : H_LEAD;
            H_LOW: begin
               if (half_done) begin
                  sclk_q <= 1'h1;
                  state_q <= H_HIGH;
               end
            end
            H_HIGH: begin
               if (half_done) begin
                  sclk_q <= 1'h0;
                  state_q <= (bit_q == last_q) ? H_TAIL : H_LOW;
               end
            end
            H_TAIL: begin
               if (half_done) begin
                  cs_n_q <= 1'h1;
                  state_q <= H_IDLE;
               end
            end
            default: state_q <= H_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         bit_q <= 6'h00;
         last_q <= 6'h00;
         tx_q <= 48'h0;
         rx_q <= 32'h0;
         rd_q <= 1'h0;
         drv_q <= 1'h0;
         oe_n_q <= 1'h1;
      end else if (start) begin
         bit_q <= 6'h00;
         last_q <= last_d;
         tx_q <= seq;
         rx_q <= 32'h0;
         rd_q <= instr[scp_pkg::RW_BIT];
      end else if ((state_q == H_LEAD) & half_done) begin
         drv_q <= tx_q[0];
         oe_n_q <= 1'h0;
      end else if (turn) begin
         // The device takes over the line a few cycles after it sees the
         // last instruction rise, so let go right after that rise.
         oe_n_q <= 1'h1;
      end else if ((state_q == H_HIGH) & half_done) begin
         if (rd_q & in_data) begin
            rx_q[rx_idx] <= din;
         end
         bit_q <= bit_q + 6'h01;
         tx_q <= tx_q >> 1;
         drv_q <= tx_q[1];
      end else if ((state_q == H_TAIL) & half_done) begin
         oe_n_q <= 1'h1;
      end
   end

   // ***********************************************
   // Register port
   // ***********************************************
   always_comb begin
      for (int k = 0; k < 4; k++) begin
         rx_conv[8*k +: 8] = lsb ? rx_q[8*k +: 8] : scp_pkg::rev8(rx_q[8*k +: 8]);
      end
   end

   wire hit_wd = reg_addr == scp_pkg::HREG_WDATA;
   wire hit_rd = reg_addr == scp_pkg::HREG_RDATA;
   wire hit_st = reg_addr == scp_pkg::HREG_STATUS;
   wire hit_cf = reg_addr == scp_pkg::HREG_CFG;
   wire [31:0] rd_mux = hit_wd ? wdata_q :
                        hit_rd ? rx_conv :
                        hit_st ? {31'h0, busy} :
                        hit_cf ? {22'h0, cfg_q} : 32'h0;

   always_ff @(posedge clk) begin
      if (srst) begin
         cfg_q <= 10'h000;
         wdata_q <= 32'h0;
         rdata_q <= 32'h0;
      end else begin
         cfg_q <= (reg_wr & hit_cf) ? reg_wdata[9:0] : cfg_q;
         wdata_q <= (reg_wr & hit_wd & ~busy) ? reg_wdata : wdata_q;
         rdata_q <= reg_rd ? rd_mux : 32'h0;
      end
   end

   assign reg_rdata = rdata_q;
   assign link.cs_n = cs_n_q;
   assign link.sclk = sclk_q;
   assign link.host_sdio_drv = drv_q;
   assign link.host_sdio_oe_n = oe_n_q;
endmodule : scp_host

// ---- scp_link_properties.sv ----
module scp_link_properties (
   // Clock and reset
   input wire logic clk,
   input wire logic srst,
   // Link signals
   input wire logic cs_n,
   input wire logic sclk,
   input wire logic host_sdio_drv,
   input wire logic host_sdio_oe_n,
   input wire logic dev_sdio_drv,
   input wire logic dev_sdio_oe_n,
   input wire logic dev_sdo_oe_n
);
   logic sclk_q;
   logic [6:0] rise_cnt_q;
   logic [6:0] rise_cnt_d;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (srst);

   // ***********************************************
   // Serial clock rises within the current frame
   // ***********************************************
   assign rise_cnt_d = (sclk && !sclk_q) ? rise_cnt_q + 7'h01 : rise_cnt_q;
   always_ff @(posedge clk) begin
      sclk_q <= sclk;
      rise_cnt_q <= (srst || cs_n) ? 7'h00 : rise_cnt_d;
   end

   // ***********************************************
   // Properties
   // ***********************************************
   sclk_high_a: assert property ($rose(sclk) |-> sclk [*8] ##1 !sclk)
      else $error("sclk high phase is not 8 cycles");
   sclk_low_a: assert property ($fell(sclk) |-> (!sclk) [*8])
      else $error("sclk low phase shorter than 8 cycles");
   host_hold_a: assert property (!host_sdio_oe_n && sclk && $past(sclk) |-> $stable(host_sdio_drv))
      else $error("host data moved while sclk high");
   read_setup_a: assert property ($fell(sclk) && !dev_sdio_oe_n |-> $past(dev_sdio_drv, 2) == dev_sdio_drv)
      else $error("read bit not settled at sclk fall");
   no_clash_a: assert property (host_sdio_oe_n || dev_sdio_oe_n)
      else $error("both ends drive sdio");
   one_output_a: assert property (dev_sdio_oe_n || dev_sdo_oe_n)
      else $error("device drives sdio and sdo together");
   release_a: assert property (cs_n [*5] |-> dev_sdio_oe_n && dev_sdo_oe_n)
      else $error("device drives while deselected");
   lead_time_a: assert property ($fell(cs_n) |-> (!sclk) [*8])
      else $error("sclk rose too soon after select");
   frame_len_a: assert property ($rose(cs_n) |-> rise_cnt_q[2:0] == 3'h0 && rise_cnt_q >= 7'h10)
      else $error("frame not whole bytes after instruction");
   instr_quiet_a: assert property (!cs_n && rise_cnt_q < 7'h10 |-> dev_sdio_oe_n && dev_sdo_oe_n)
      else $error("device drove during instruction");
   cover property ($rose(cs_n) && rise_cnt_q >= 7'h30);
   cover property ($fell(sclk) && !dev_sdio_oe_n);
   cover property (!dev_sdo_oe_n);
endmodule : scp_link_properties

// ---- tb_serial_control_port.sv ----
module tb_serial_control_port;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'h0;
   logic srst = 1'h1;
   logic [7:0] reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h0;
   logic reg_wr = 1'h0;
   logic reg_rd = 1'h0;
   logic [31:0] reg_rdata;
   logic [9:0] tap_addr = 10'h000;
   logic [7:0] tap_data;
   logic update_pulse;
   logic [31:0] d;
   logic [31:0] r;
   int err_count = 0;
   int check_count = 0;
   int seed = 6;
   int cyc = 0;
   int upd_seen = 0;

   scp_if scp_if_i ();
   scp_device scp_device_i (.clk(clk), .srst(srst), .link(scp_if_i.dev), .tap_addr(tap_addr),
      .tap_data(tap_data), .update_pulse(update_pulse));
   scp_host scp_host_i (.clk(clk), .srst(srst), .link(scp_if_i.host), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
   scp_link_properties scp_link_properties_i (.clk(clk), .srst(srst), .cs_n(scp_if_i.cs_n),
      .sclk(scp_if_i.sclk), .host_sdio_drv(scp_if_i.host_sdio_drv), .host_sdio_oe_n(scp_if_i.host_sdio_oe_n),
      .dev_sdio_drv(scp_if_i.dev_sdio_drv), .dev_sdio_oe_n(scp_if_i.dev_sdio_oe_n),
      .dev_sdo_oe_n(scp_if_i.dev_sdo_oe_n));

   // ***********************************************
   // Helpers
   // ***********************************************
   task automatic end_sim();
      $display("Checks %0d errors %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : end_sim

   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp) begin
         $display("Error %s expected %h seen %h", name, exp, got);
         err_count++;
      end
   endtask : chk

   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'h1;
      @(posedge clk);
      reg_wr <= 1'h0;
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [31:0] v);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'h1;
      @(posedge clk);
      reg_rd <= 1'h0;
      #1;
      v = reg_rdata;
   endtask : rd

   function automatic logic [31:0] ins(input logic rw, input scp_pkg::scp_len_t len, input logic [9:0] a);
      return {16'h0000, rw, len, 3'h0, a};
   endfunction : ins

   // The top address bits go out as zero, so every command word is legal.
   task automatic xfer(input logic [31:0] cmd, input logic [31:0] v, output logic [31:0] q);
      logic [31:0] s;
      s = 32'h1;
      wr(scp_pkg::HREG_WDATA, v);
      wr(scp_pkg::HREG_CMD, cmd);
      for (int i = 0; i < 2000 && s[0] !== 1'h0; i++) begin
         rd(scp_pkg::HREG_STATUS, s);
      end
      // A transfer that never finishes counts against the run.
      if (s[0] !== 1'h0) begin
         $display("Error busy expected 0 seen %h", s[0]);
         err_count++;
      end
      rd(scp_pkg::HREG_RDATA, q);
   endtask : xfer

   task automatic tap(input logic [9:0] a, input logic [7:0] e);
      @(posedge clk);
      tap_addr <= a;
      @(posedge clk);
      #1;
      chk("tap_data", {24'h0, e}, {24'h0, tap_data});
   endtask : tap

   // ***********************************************
   // Run
   // ***********************************************
   initial begin
      forever #25 clk = ~clk;
   end

   always @(posedge clk) begin
      cyc++;
      if (update_pulse === 1'h1) begin
         upd_seen++;
      end
      if (cyc == 40000) begin
         err_count++;
         end_sim();
      end
   end

   initial begin
      repeat (8) @(posedge clk);
      srst <= 1'h0;
      tap(10'h000, scp_pkg::PORT_CFG_RST);
      d = $random(seed);
      xfer(ins(1'h0, scp_pkg::LEN_TWO, 10'h011), d, r);
      tap(10'h011, 8'h00);
      xfer(ins(1'h1, scp_pkg::LEN_TWO, 10'h011), 32'h0, r);
      chk("buffer read", {16'h0, d[15:0]}, {16'h0, r[15:0]});
      xfer(ins(1'h0, scp_pkg::LEN_ONE, scp_pkg::ADDR_UPDATE), 32'h1, r);
      chk("update_pulse", 32'h1, upd_seen);
      tap(10'h011, d[7:0]);
      tap(10'h010, d[15:8]);
      xfer(ins(1'h0, scp_pkg::LEN_ONE, scp_pkg::ADDR_RB_SEL), 32'h1, r);
      xfer(ins(1'h0, scp_pkg::LEN_ONE, 10'h011), ~d, r);
      xfer(ins(1'h1, scp_pkg::LEN_ONE, 10'h011), 32'h0, r);
      chk("active read", {24'h0, d[7:0]}, {24'h0, r[7:0]});
      // Four bytes asked for, but the stream must stop after 0x232.
      wr(scp_pkg::HREG_CFG, 32'h300);
      xfer(ins(1'h1, scp_pkg::LEN_STREAM, 10'h001), 32'h0, r);
      chk("stream read", 32'h00001800, {8'h0, r[23:0]});
      xfer(ins(1'h0, scp_pkg::LEN_ONE, scp_pkg::ADDR_PORT_CFG), 32'h5A, r);
      wr(scp_pkg::HREG_CFG, 32'h1);
      tap(10'h000, 8'h5A);
      d = $random(seed);
      xfer(ins(1'h0, scp_pkg::LEN_THREE, 10'h020), d, r);
      xfer(ins(1'h0, scp_pkg::LEN_ONE, scp_pkg::ADDR_UPDATE), 32'h1, r);
      for (int k = 0; k < 3; k++) begin
         tap(10'h020 + 10'(k), d[8*k +: 8]);
      end
      xfer(ins(1'h1, scp_pkg::LEN_THREE, 10'h020), 32'h0, r);
      chk("lsb read", {8'h0, d[23:0]}, {8'h0, r[23:0]});
      xfer(ins(1'h0, scp_pkg::LEN_ONE, scp_pkg::ADDR_PORT_CFG), 32'hDB, r);
      wr(scp_pkg::HREG_CFG, 32'h3);
      xfer(ins(1'h1, scp_pkg::LEN_ONE, 10'h021), 32'h0, r);
      chk("sdo read", {24'h0, d[15:8]}, {24'h0, r[7:0]});
      xfer(ins(1'h0, scp_pkg::LEN_ONE, scp_pkg::ADDR_PORT_CFG), 32'h3C, r);
      wr(scp_pkg::HREG_CFG, 32'h0);
      tap(10'h020, 8'h00);
      xfer(ins(1'h0, scp_pkg::LEN_ONE, scp_pkg::ADDR_PORT_CFG), 32'h18, r);
      tap(10'h000, 8'h18);
      end_sim();
   end
endmodule : tb_serial_control_port
